// file: common/watchdog_defs.svh
// Constants for the system watchdog timer
`ifndef WATCHDOG_DEFS_SVH
`define WATCHDOG_DEFS_SVH
`define WD_CNT_W 16
`define WD_BYTE_W 8
`define WD_PRE_W 8
`define WD_SEL_DIV2 2'h0
`define WD_SEL_DIV4 2'h1
`define WD_SEL_DIV128 2'h2
`define WD_SEL_DIV256 2'h3
`define WD_PRE_DIV2 8'h01
`define WD_PRE_DIV4 8'h03
`define WD_PRE_DIV128 8'h7f
`define WD_PRE_DIV256 8'hff
`define WD_RST_SEL 2'h0
`define WD_RST_RELOAD 8'h00
`define WD_LOW_CLEAR 8'h00
`define WD_CNT_MAX 16'hffff
`define WD_RST_HOLD 8'h04
`define WD_DEF_INTERVAL_US 3280
`define WD_CLK_MHZ 40
`endif

// file: common/watchdog_pkg.sv
// Types for the system watchdog timer
package watchdog_pkg;
  typedef enum logic [1:0] {ST_RUN, ST_OFF, ST_RESET} wd_state_t;
endpackage : watchdog_pkg

// file: common/wd_tick_if.sv
// Prescaler tick carrier between watchdog and its divider
`timescale 1ns/1ps
interface wd_tick_if;
  logic [1:0] sel;
  logic restart;
  logic tick;
  modport ctrl (output sel, output restart, input tick);
  modport div (input sel, input restart, output tick);
endinterface : wd_tick_if

// file: verilog/wd_prescaler.sv
// Selectable system clock prescaler for the watchdog
`timescale 1ns/1ps
`include "watchdog_defs.svh"
module wd_prescaler
(
  // Clock and control
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Tick carrier
  wd_tick_if.div tk
);
  logic [`WD_PRE_W-1:0] pre_reg;
  logic [`WD_PRE_W-1:0] pre_next;
  logic [`WD_PRE_W-1:0] limit;
  logic at_limit;

  function automatic logic [`WD_PRE_W-1:0] div_limit(input logic [1:0] s);
    case (s)
      `WD_SEL_DIV2: div_limit = `WD_PRE_DIV2;
      `WD_SEL_DIV4: div_limit = `WD_PRE_DIV4;
      `WD_SEL_DIV128: div_limit = `WD_PRE_DIV128;
      default: div_limit = `WD_PRE_DIV256;
    endcase
  endfunction : div_limit

  // Divide by 2, 4, 128 or 256
  assign limit = div_limit(tk.sel);
  assign at_limit = (pre_reg >= limit);
  assign pre_next = (tk.restart || at_limit) ? '0 : pre_reg + 8'h01;
  assign tk.tick = at_limit && !tk.restart;

  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
      pre_reg <= '0;
    else if (clk_en)
      pre_reg <= pre_next;
  end
endmodule : wd_prescaler

// file: verilog/system_watchdog_timer.sv
// System watchdog timer top level
// ==========================================================
// Functional notes
// - The watchdog runs and is enabled right after every reset.
// - In compatible mode a disable is taken only before end of init.
// - In enhanced mode enable is taken at any time, disable while running and not in a service or overflow cycle.
// - Overflow raises an internal reset and drives the reset pin low.
// - The 16-bit counter counts the system clock divided by 2/4/128/256.
// - The upper byte reload comes from a software reload value.
// - A service loads the upper byte and clears the lower byte.
// - Reset settings give a 3.28 ms interval at 40 MHz.
`timescale 1ns/1ps
`include "watchdog_defs.svh"
module system_watchdog_timer
#(
  parameter logic [7:0] RST_HOLD = `WD_RST_HOLD
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Instruction strobes
  input wire logic service_instruction,
  input wire logic end_of_init_instruction,
  input wire logic supervisor_disable_instruction,
  input wire logic supervisor_enable_instruction,
  // Configuration
  input wire logic enhanced_mode,
  input wire logic [1:0] prescale_sel,
  input wire logic prescale_load,
  input wire logic [7:0] supervisor_reload_value,
  input wire logic reload_load,
  // Status and reset outputs
  output logic [15:0] count_value,
  output logic enabled,
  output logic init_done,
  output logic internal_reset,
  output logic reset_output_pin_n
);
  // ========================================================
  // State
  watchdog_pkg::wd_state_t state_reg, state_next;
  logic [`WD_CNT_W-1:0] cnt_reg, cnt_next;
  logic [`WD_BYTE_W-1:0] reload_reg;
  logic [1:0] sel_reg;
  logic init_reg;
  logic [7:0] hold_reg, hold_next;

  wd_tick_if tk ();

  wd_prescaler u_pre
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .tk(tk)
  );

  // ========================================================
  // Decoding
  wire running = (state_reg == watchdog_pkg::ST_RUN);
  wire dis_ok = enhanced_mode || !init_reg;
  wire dis_take = supervisor_disable_instruction && dis_ok;
  wire en_take = supervisor_enable_instruction && enhanced_mode;
  wire overflow = running && tk.tick && !service_instruction
                  && (cnt_reg == `WD_CNT_MAX);
  wire [`WD_CNT_W-1:0] serviced = {reload_reg, `WD_LOW_CLEAR};
  assign tk.sel = sel_reg;
  assign tk.restart = service_instruction;

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    hold_next = hold_reg;
    case (state_reg)
      watchdog_pkg::ST_RUN:
      begin
        if (overflow)
        begin
          state_next = watchdog_pkg::ST_RESET;
          hold_next = RST_HOLD;
        end
        else if (service_instruction)
          cnt_next = serviced;
        else if (dis_take)
          state_next = watchdog_pkg::ST_OFF;
        else if (tk.tick)
          cnt_next = cnt_reg + 16'h0001;
      end
      watchdog_pkg::ST_OFF:
      begin
        if (service_instruction)
          cnt_next = serviced;
        if (en_take)
          state_next = watchdog_pkg::ST_RUN;
      end
      watchdog_pkg::ST_RESET:
      begin
        // The pin is held a few cycles so slow external parts see it
        if (hold_reg == 8'h00)
        begin
          state_next = watchdog_pkg::ST_RUN;
          cnt_next = '0;
        end
        else
          hold_next = hold_reg - 8'h01;
      end
      default: state_next = watchdog_pkg::ST_RUN;
    endcase
  end

  // ========================================================
  // Registers
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      state_reg <= watchdog_pkg::ST_RUN;
      cnt_reg <= '0;
      hold_reg <= '0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      hold_reg <= hold_next;
    end
  end

  // Settings also return to defaults after a watchdog reset
  always_ff @(posedge ref_clk)
  begin
    if (!nrst || (clk_en && state_reg == watchdog_pkg::ST_RESET))
    begin
      sel_reg <= `WD_RST_SEL;
      reload_reg <= `WD_RST_RELOAD;
      init_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      if (prescale_load)
        sel_reg <= prescale_sel;
      if (reload_load)
        reload_reg <= supervisor_reload_value;
      if (end_of_init_instruction)
        init_reg <= 1'b1;
    end
  end

  // Outputs straight from flip-flops
  always_ff @(posedge ref_clk)
  begin
    if (!nrst)
    begin
      count_value <= '0;
      enabled <= 1'b1;
      init_done <= 1'b0;
      internal_reset <= 1'b0;
      reset_output_pin_n <= 1'b1;
    end
    else if (clk_en)
    begin
      count_value <= cnt_next;
      enabled <= (state_next != watchdog_pkg::ST_OFF);
      init_done <= init_reg || end_of_init_instruction;
      internal_reset <= (state_next == watchdog_pkg::ST_RESET);
      reset_output_pin_n <= (state_next != watchdog_pkg::ST_RESET);
    end
  end

  // ========================================================
  // Assertions
  a_reset_on_overflow: assert property (@(posedge ref_clk)
    disable iff (!nrst) (clk_en && overflow) |=> !reset_output_pin_n
      && internal_reset)
    else $error("overflow did not drive reset");
  a_compat_locks: assert property (@(posedge ref_clk)
    disable iff (!nrst) (clk_en && running && init_reg && !enhanced_mode
      && !overflow) |=> enabled)
    else $error("disable accepted after end of init");
  a_service_loads: assert property (@(posedge ref_clk)
    disable iff (!nrst) (clk_en && running && service_instruction)
      |=> count_value == {$past(reload_reg), 8'h00})
    else $error("service did not reload counter");
  a_enh_enable: assert property (@(posedge ref_clk)
    disable iff (!nrst) (clk_en && state_reg == watchdog_pkg::ST_OFF
      && en_take) |=> enabled)
    else $error("enable instruction ignored");
  a_start_enabled: assert property (@(posedge ref_clk)
    $rose(nrst) |-> enabled)
    else $error("not enabled after reset");
  a_count_step: assert property (@(posedge ref_clk)
    disable iff (!nrst) (clk_en && running && tk.tick && !overflow
      && !service_instruction && !dis_take)
      |=> count_value == $past(cnt_reg) + 16'h0001)
    else $error("counter did not step on tick");
  a_reset_release: assert property (@(posedge ref_clk)
    disable iff (!nrst) $rose(internal_reset) |-> ##[1:300]
      !internal_reset)
    else $error("reset never released");
  a_reload_default: assert property (@(posedge ref_clk)
    $rose(nrst) |-> reload_reg == 8'h00 && sel_reg == 2'h0)
    else $error("bad reset defaults");
  a_off_holds_count: assert property (@(posedge ref_clk)
    disable iff (!nrst) (clk_en && state_reg == watchdog_pkg::ST_OFF
      && !service_instruction) |=> $stable(count_value))
    else $error("counter moved while disabled");
  a_freeze_all: assert property (@(posedge ref_clk)
    disable iff (!nrst) !clk_en |=> $stable(count_value)
      && $stable(enabled) && $stable(reset_output_pin_n))
    else $error("state moved while clock enable low");
  c_overflow: cover property (@(posedge ref_clk) overflow);
  c_service: cover property (@(posedge ref_clk)
    running && service_instruction);
  c_enh_off_on: cover property (@(posedge ref_clk)
    state_reg == watchdog_pkg::ST_OFF ##[1:20] running);
  c_pin_pulse: cover property (@(posedge ref_clk)
    $fell(reset_output_pin_n));
  c_freeze: cover property (@(posedge ref_clk) !clk_en && running);
endmodule : system_watchdog_timer

// file: tb/sw_model.sv
// Software side model that issues watchdog instructions
`timescale 1ns/1ps
module sw_model
(
  // Clock
  input wire logic ref_clk,
  // Instruction strobes
  output logic service,
  output logic eoi,
  output logic dis,
  output logic ena
);
  initial
  begin
    service = 1'b0;
    eoi = 1'b0;
    dis = 1'b0;
    ena = 1'b0;
  end
  // One-cycle strobe, launched off the sampling edge to avoid races
  task op(input logic [1:0] code);
    @(negedge ref_clk);
    service = (code == 2'h0);
    eoi = (code == 2'h1);
    dis = (code == 2'h2);
    ena = (code == 2'h3);
    @(negedge ref_clk);
    service = 1'b0;
    eoi = 1'b0;
    dis = 1'b0;
    ena = 1'b0;
  endtask : op
endmodule : sw_model

// file: tb/tb.sv
// Self-checking testbench for the system watchdog timer
`timescale 1ns/1ps
module tb;
  logic ref_clk, nrst, clk_en, enhanced_mode, prescale_load, reload_load;
  logic [1:0] prescale_sel;
  logic [7:0] reload;
  logic [15:0] count_value, c0;
  logic enabled, init_done, internal_reset, pin_n, svc, eoi, dis, ena;
  int n_mismatch = 0;
  int total_checks = 0;
  int n;
  sw_model sw
  (
    .ref_clk(ref_clk),
    .service(svc),
    .eoi(eoi),
    .dis(dis),
    .ena(ena)
  );
  // Short reset hold keeps the pulse length check quick
  system_watchdog_timer
  #(
    .RST_HOLD(8'h01)
  )
  dut
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .service_instruction(svc),
    .end_of_init_instruction(eoi),
    .supervisor_disable_instruction(dis),
    .supervisor_enable_instruction(ena),
    .enhanced_mode(enhanced_mode),
    .prescale_sel(prescale_sel),
    .prescale_load(prescale_load),
    .supervisor_reload_value(reload),
    .reload_load(reload_load),
    .count_value(count_value),
    .enabled(enabled),
    .init_done(init_done),
    .internal_reset(internal_reset),
    .reset_output_pin_n(pin_n)
  );
  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  // ==========================================================
  // Helpers
  task check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task end_sim;
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  task do_reset;
    @(negedge ref_clk);
    nrst = 1'b0;
    repeat (3) @(negedge ref_clk);
    nrst = 1'b1;
  endtask : do_reset
  task cfg(input logic [1:0] sel, input logic [7:0] rel);
    @(negedge ref_clk);
    prescale_sel = sel;
    reload = rel;
    prescale_load = 1'b1;
    reload_load = 1'b1;
    @(negedge ref_clk);
    prescale_load = 1'b0;
    reload_load = 1'b0;
  endtask : cfg
  // Counting over a whole multiple of the divider hides the tick phase
  task delta(input int cycles, input logic [15:0] exp);
    c0 = count_value;
    repeat (cycles) @(negedge ref_clk);
    check(count_value - c0, exp);
  endtask : delta
  // ==========================================================
  // Tests
  initial
  begin
    nrst = 1'b0;
    clk_en = 1'b1;
    enhanced_mode = 1'b0;
    prescale_load = 1'b0;
    reload_load = 1'b0;
    prescale_sel = 2'h0;
    reload = 8'h00;
    do_reset;
    check({13'h0, enabled, init_done, pin_n}, 16'h0005);
    check(count_value, 16'h0000);
    delta(32, 16'h0010);
    cfg(2'h1, 8'h00);
    sw.op(2'h0);
    delta(128, 16'h0020);
    cfg(2'h2, 8'h00);
    sw.op(2'h0);
    delta(1024, 16'h0008);
    cfg(2'h3, 8'h00);
    sw.op(2'h0);
    delta(2048, 16'h0008);
    cfg(2'h0, 8'h5a);
    sw.op(2'h0);
    check(count_value, 16'h5a00);
    cfg(2'h0, 8'hff);
    sw.op(2'h0);
    n = 0;
    while (pin_n !== 1'b0 && n < 600)
    begin
      @(negedge ref_clk);
      n++;
    end
    check(16'(n >= 505 && n <= 515), 16'h0001);
    check({15'h0, internal_reset}, 16'h0001);
    n = 0;
    while (pin_n === 1'b0 && n < 10)
    begin
      @(negedge ref_clk);
      n++;
    end
    check(16'(n), 16'h0002);
    check({15'h0, enabled}, 16'h0001);
    delta(32, 16'h0010);
    // Reload was 8'hff before the overflow; the watchdog reset clears it
    sw.op(2'h0);
    check(count_value, 16'h0000);
    do_reset;
    sw.op(2'h2);
    check({15'h0, enabled}, 16'h0000);
    sw.op(2'h3);
    check({15'h0, enabled}, 16'h0000);
    do_reset;
    sw.op(2'h1);
    check({15'h0, init_done}, 16'h0001);
    sw.op(2'h2);
    check({15'h0, enabled}, 16'h0001);
    enhanced_mode = 1'b1;
    sw.op(2'h2);
    check({15'h0, enabled}, 16'h0000);
    delta(8, 16'h0000);
    sw.op(2'h3);
    check({15'h0, enabled}, 16'h0001);
    // A service while switched off still loads the counter
    sw.op(2'h2);
    cfg(2'h0, 8'h33);
    sw.op(2'h0);
    check(count_value, 16'h3300);
    sw.op(2'h3);
    check({15'h0, enabled}, 16'h0001);
    // Clock enable low freezes everything, strobes included
    clk_en = 1'b0;
    sw.op(2'h2);
    check({15'h0, enabled}, 16'h0001);
    delta(16, 16'h0000);
    clk_en = 1'b1;
    delta(16, 16'h0008);
    end_sim;
  end
  // Whole sequence needs well under 5000 cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    end_sim;
  end
endmodule : tb
